// File: common/ebi_link_if.sv
`timescale 1ns/100ps
interface ebi_link_if;
  logic [7:0] div;
  logic       sdram_en;
  logic       tick;
  logic       holdoff_done;
  modport core  (output div, output sdram_en, input tick, input holdoff_done);
  modport timer (input div, input sdram_en, output tick, output holdoff_done);
endinterface

// File: common/ebi_map.svh
`ifndef EBI_MAP_SVH
`define EBI_MAP_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define EBI_OFF_CTRL    8'h00
`define EBI_OFF_GPCFG   8'h04
`define EBI_OFF_ADDR    8'h08
`define EBI_OFF_WDATA   8'h0C
`define EBI_OFF_CMD     8'h10
`define EBI_OFF_RDATA   8'h14
`define EBI_OFF_NBRDATA 8'h18
`define EBI_OFF_STATUS  8'h1C
`define EBI_OFF_MASK    8'h20
`define EBI_OFF_STATE   8'h24
// ----------------------------------------
// Field positions
// ----------------------------------------
`define EBI_CTRL_MODE_LSB 0
`define EBI_CTRL_FRAME    4
`define EBI_CTRL_STRB     5
`define EBI_CTRL_DIV_LSB  8
`define EBI_CMD_WRITE     0
`define EBI_CMD_NBR       1
`define EBI_CMD_BYTE      2
`define EBI_ST_NBR        0
`define EBI_ST_TMO        1
// ----------------------------------------
// Reset values
// ----------------------------------------
`define EBI_CTRL_RST  32'h0000_0000
`define EBI_GPCFG_RST 32'h0000_0010
// ----------------------------------------
// Timing
// ----------------------------------------
`define EBI_CLK_NS      20
`define EBI_HOLDOFF_US  100
`define EBI_HOLDOFF_CYC ((`EBI_HOLDOFF_US * 1000 + `EBI_CLK_NS - 1) / `EBI_CLK_NS)
`endif

// File: common/ebi_pkg.sv
package ebi_pkg;
  // Operating modes of the external bus
  typedef enum logic [1:0] {
    EBI_MODE_OFF   = 2'b00,
    EBI_MODE_SDRAM = 2'b01,
    EBI_MODE_HB16  = 2'b10,
    EBI_MODE_GP    = 2'b11
  } ebi_mode_type;
  // Access engine states
  typedef enum logic [2:0] {
    EBI_IDLE   = 3'b000,
    EBI_HOLD   = 3'b001,
    EBI_SETUP  = 3'b010,
    EBI_STROBE = 3'b011,
    EBI_WAIT   = 3'b100,
    EBI_DONE   = 3'b101
  } ebi_state_type;
endpackage

// File: testbench/ebi_ext_dev.sv
`timescale 1ns/100ps
module ebi_ext_dev (
  input  wire logic        clk_i,
  input  wire logic        cs_n_i,
  input  wire logic [15:0] addr_i,
  input  wire logic        stall_i,
  output logic      [15:0] data_o,
  output logic             ready_o
);
  // ----------------------------------------
  // Parallel device model
  // ----------------------------------------
  logic [15:0] last_reg;

  // Data from address while selected, inverse of last value when released
  always_comb begin
    data_o = cs_n_i ? ~last_reg : {addr_i[7:0], ~addr_i[7:0]};
  end

  // Remember the last value driven while selected, so the released lines hold still
  always_ff @(posedge clk_i) begin
    if (!cs_n_i) begin
      last_reg <= data_o;
    end
  end

  // Ready only while selected; a stall holds it low only while stall_i is high
  assign ready_o = !cs_n_i && !stall_i;
endmodule // ebi_ext_dev

// File: testbench/ebi_top_tb.sv
`timescale 1ns/100ps
`include "ebi_map.svh"
module ebi_top_tb;
  import ebi_pkg::*;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  localparam int          HOLD = 20;
  logic        clk = 0, rst = 1, hsel = 0, hwrite = 0, stall = 0, cs_q = 1;
  logic [1:0]  htrans = 2'b00;
  logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata;
  logic        hready, hresp, irq, cs_n, frm, frm_oen, rd_s, rd_oen, wr_s, wr_oen, d_oen, rdy;
  logic [15:0] ext_addr, ext_din, ext_dout;
  logic [1:0]  bsel_n;
  int          cyc = 0, cs_fall = 0, rd_cnt = 0, bsel_bad = 0, bad_count = 0, n_checks = 0;

  always #10 clk = ~clk;

  ebi_top #(.HOLDOFF_CYCLES(HOLD), .NBR_DEPTH(4)) i_dut (
    .CLK_I(clk), .RESET_I(rst), .CE_I(1'b1), .HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htrans),
    .HWRITE_I(hwrite), .HSIZE_I(3'b010), .HREADY_I(hready), .HWDATA_I(hwdata), .HRDATA_O(hrdata),
    .HREADYOUT_O(hready), .HRESP_O(hresp), .IRQ_O(irq), .EXT_ADDR_O(ext_addr), .EXT_DATA_I(ext_din),
    .EXT_DATA_O(ext_dout), .EXT_DATA_OEN_O(d_oen), .EXT_CS_N_O(cs_n), .EXT_BSEL_N_O(bsel_n),
    .EXT_FRAME_O(frm), .EXT_FRAME_OEN_O(frm_oen), .EXT_RD_O(rd_s), .EXT_RD_OEN_O(rd_oen),
    .EXT_WR_O(wr_s), .EXT_WR_OEN_O(wr_oen), .EXT_READY_I(rdy)
  );

  // Frame and strobe pins go to no device: the board gives them to other functions
  ebi_ext_dev i_dev (.clk_i(clk), .cs_n_i(cs_n), .addr_i(ext_addr), .stall_i(stall),
    .data_o(ext_din), .ready_o(rdy));

  // ----------------------------------------
  // Pin monitor and timeout
  // ----------------------------------------
  always @(posedge clk) begin
    cyc <= cyc + 1;
    cs_q <= cs_n;
    if (cs_n === 1'b0 && cs_q === 1'b1) cs_fall <= cyc;
    if (rd_s === 1'b1) rd_cnt <= rd_cnt + 1;
    if (cs_n === 1'b0 && rd_s === 1'b1 && bsel_n !== 2'b00) bsel_bad <= bsel_bad + 1;
    if (cyc > 20000) begin
      bad_count = bad_count + 1;
      test_done();
    end
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One single AHB transfer, waiting on ready in both phases
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    int n;
    @(posedge clk);
    hsel <= 1'b1; htrans <= 2'b10; haddr <= {24'h00_0000, a}; hwrite <= w;
    n = 0;
    do begin @(posedge clk); n++; end while (hready !== 1'b1 && n < 100);
    hsel <= 1'b0; htrans <= 2'b00; hwdata <= wd;
    n = 0;
    do begin @(posedge clk); n++; end while (hready !== 1'b1 && n < 100);
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    ahb(1'b1, a, d, x);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    ahb(1'b0, a, 32'h0000_0000, d);
  endtask

  // Poll the engine state until idle
  task automatic idle();
    logic [31:0] s;
    int n;
    n = 0;
    do begin rd(`EBI_OFF_STATE, s); n++; end while (s[2:0] !== 3'b000 && n < 200);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    logic [31:0] d;
    rd(`EBI_OFF_CTRL, d);  chk("ctrl", d, `EBI_CTRL_RST);
    rd(`EBI_OFF_GPCFG, d); chk("gpcfg", d, `EBI_GPCFG_RST);
    rd(8'h3C, d);          chk("unmapped", d, 32'h0000_0000);
    chk("irq", irq, 1'b0);
    chk("cs_n", cs_n, 1'b1);
    // Command refused while the bus mode is off
    wr(`EBI_OFF_CMD, 32'h0000_0000);
    rd(`EBI_OFF_STATE, d); chk("off_refused", d[2:0], 3'h0);
    $display("reset test done");
  endtask

  task automatic t_gate();
    for (int i = 0; i < 4; i++) begin
      wr(`EBI_OFF_CTRL, 32'h0000_0003 | (i << 4));
      @(negedge clk); // Let the new pin enables settle
      chk("frame_oen", frm_oen, !i[0]);
      chk("rd_oen", rd_oen, !i[1]);
      chk("wr_oen", wr_oen, !i[1]);
    end
    $display("gate test done");
  endtask

  task automatic t_hb16();
    logic [31:0] d;
    int b0;
    b0 = bsel_bad;
    // Divider 2: strobe outlasts the two-stage data synchroniser
    wr(`EBI_OFF_CTRL, 32'h0000_0202);
    wr(`EBI_OFF_ADDR, 32'h0000_0035);
    wr(`EBI_OFF_CMD, 32'h0000_0004);
    idle();
    chk("bsel_bad", bsel_bad - b0, 0);
    rd(`EBI_OFF_RDATA, d); chk("byte", d, 32'h0000_0035);
    $display("hb16 test done");
  endtask

  task automatic t_nbr();
    logic [31:0] d;
    int n;
    wr(`EBI_OFF_CTRL, 32'h0000_0033);
    wr(`EBI_OFF_MASK, 32'h0000_0001);
    wr(`EBI_OFF_ADDR, 32'h0000_0042);
    wr(`EBI_OFF_CMD, 32'h0000_0002);
    n = 0;
    while (irq !== 1'b1 && n < 200) begin @(posedge clk); n++; end
    chk("irq_done", irq, 1'b1);
    rd(`EBI_OFF_STATE, d); chk("count1", d[15:8], 8'h01);
    wr(`EBI_OFF_ADDR, 32'h0000_0070);
    wr(`EBI_OFF_CMD, 32'h0000_0000);
    idle();
    rd(`EBI_OFF_RDATA, d); chk("blk_rd", d, 32'h0000_708F);
    wr(`EBI_OFF_ADDR, 32'h0000_0080);
    wr(`EBI_OFF_CMD, 32'h0000_0001);
    idle();
    rd(`EBI_OFF_STATE, d); chk("count_kept", d[15:8], 8'h01);
    rd(`EBI_OFF_NBRDATA, d); chk("nbr_data", d, 32'h0000_42BD);
    rd(`EBI_OFF_STATE, d); chk("count0", d[15:8], 8'h00);
    rd(`EBI_OFF_STATUS, d); chk("st_nbr", d[0], 1'b1);
    wr(`EBI_OFF_STATUS, 32'h0000_0001);
    @(negedge clk);
    chk("irq_clr", irq, 1'b0);
    $display("nbr test done");
  endtask

  task automatic t_wait();
    logic [31:0] d;
    int r0;
    wr(`EBI_OFF_CTRL, 32'h0000_0133);
    wr(`EBI_OFF_GPCFG, 32'h0000_0003);
    stall <= 1'b1;
    r0 = rd_cnt;
    wr(`EBI_OFF_CMD, 32'h0000_0000);
    idle();
    // One strobe tick plus 3 to 4 wait ticks, two system clocks each
    chk("wait_min", (rd_cnt - r0) >= 8, 1'b1);
    chk("wait_max", (rd_cnt - r0) <= 10, 1'b1);
    rd(`EBI_OFF_STATUS, d); chk("tmo", d[1], 1'b1);
    wr(`EBI_OFF_STATUS, 32'h0000_0002);
    stall <= 1'b0;
    wr(`EBI_OFF_CMD, 32'h0000_0000);
    idle();
    rd(`EBI_OFF_STATUS, d); chk("no_tmo", d[1], 1'b0);
    $display("wait test done");
  endtask

  task automatic t_hold();
    logic [31:0] d;
    int t0;
    // Fastest and a slow interface clock; the hold-off must not shrink
    for (int i = 0; i < 2; i++) begin
      wr(`EBI_OFF_CTRL, 32'h0000_0000);
      wr(`EBI_OFF_CTRL, 32'h0000_0001 | (i * 32'h0000_0300));
      t0 = cyc;
      wr(`EBI_OFF_CMD, 32'h0000_0000);
      idle();
      chk("holdoff", (cs_fall - t0) >= HOLD, 1'b1);
      rd(`EBI_OFF_STATE, d); chk("hold_done", d[3], 1'b1);
    end
    // Software waits out the hold-off itself, then the access starts at once
    wr(`EBI_OFF_CTRL, 32'h0000_0000);
    wr(`EBI_OFF_CTRL, 32'h0000_0001);
    repeat (HOLD + 2) @(posedge clk);
    t0 = cyc;
    wr(`EBI_OFF_CMD, 32'h0000_0000);
    idle();
    chk("prompt", (cs_fall - t0) > 0 && (cs_fall - t0) < HOLD, 1'b1);
    $display("hold test done");
  endtask

  // ----------------------------------------
  // Verdict
  // ----------------------------------------
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Main sequence; unused frame and strobe pins left to the board
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_gate();
    t_hb16();
    t_nbr();
    t_wait();
    t_hold();
    test_done();
  end
endmodule // ebi_top_tb

// File: verilog/ebi_clk_timer.sv
`timescale 1ns/100ps
`include "ebi_map.svh"
module ebi_clk_timer import ebi_pkg::*; #(
  parameter int unsigned HOLDOFF_CYCLES = `EBI_HOLDOFF_CYC
) (
  input  wire logic CLK_I,
  input  wire logic RESET_I,
  input  wire logic CE_I,
  ebi_link_if.timer lk
);
  localparam int unsigned HW = $clog2(HOLDOFF_CYCLES + 1);
  logic [7:0]    div_cnt_reg;
  logic [HW-1:0] hold_cnt_reg;

  // ----------------------------------------
  // Interface clock tick
  // ----------------------------------------
  assign lk.tick = (div_cnt_reg >= lk.div); // Recovers at once when the divider is lowered

  // Divider counter, one tick per div+1 system clocks
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      div_cnt_reg <= 8'h00;
    end else if (CE_I) begin
      div_cnt_reg <= lk.tick ? 8'h00 : div_cnt_reg + 8'h01;
    end
  end

  // ----------------------------------------
  // Start-up hold-off, in system clocks
  // ----------------------------------------
  // Fixed system rate keeps 100 us at any divider
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      hold_cnt_reg <= '0;
    end else if (CE_I) begin
      if (!lk.sdram_en) begin
        hold_cnt_reg <= '0; // R01
      end else if (!lk.holdoff_done) begin
        hold_cnt_reg <= hold_cnt_reg + HW'(1); // R02
      end
    end
  end
  // Done only while SDRAM mode stays on, so a mode change never shows a stale done
  assign lk.holdoff_done = lk.sdram_en && (hold_cnt_reg == HW'(HOLDOFF_CYCLES)); // R01

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RESET_I);

  sequence s_sdram_on;
    $rose(lk.sdram_en);
  endsequence
  a_holdoff_fresh: assert property (s_sdram_on |-> !lk.holdoff_done [*8]) // R01
    else $error("hold-off ended too early");
  a_holdoff_needs_en: assert property (lk.holdoff_done |-> lk.sdram_en && hold_cnt_reg != '0) // R02
    else $error("hold-off done without sdram mode");
  a_holdoff_stuck: assert property ((lk.sdram_en && !lk.holdoff_done && CE_I) |=> hold_cnt_reg != $past(hold_cnt_reg)) // R02
    else $error("hold-off counter does not advance");
endmodule // ebi_clk_timer

// File: verilog/ebi_top.sv
// Notes on behaviour
// R01: After SDRAM mode is enabled no SDRAM access starts until 100 us have passed.
// R02: The hold-off is timed in system clocks, so it holds at any interface clock rate.
// R03: Software should itself wait 100 us after enabling SDRAM mode before the first access.
// R04: In 16-bit host-bus mode both byte selects are asserted on every read.
// R05: The non-blocking read count moves only on non-blocking read issue and completion; the code moves it on completion and on NBRDATA reads instead.
// R06: A finished non-blocking read raises the completion interrupt; software waits for it.
// R07: In general-purpose mode the frame pin is driven only when its enable bit is set.
// R08: In general-purpose mode the read and write strobes are driven only when enabled.
// R09: The ready wait is bounded by the programmed limit, counted in interface clocks.
// R10: Software should give unused frame or strobe pins to another function.
`timescale 1ns/100ps
`include "ebi_map.svh"
module ebi_top import ebi_pkg::*; #(
  parameter int unsigned HOLDOFF_CYCLES = `EBI_HOLDOFF_CYC,
  parameter int unsigned NBR_DEPTH      = 4
) (
  input  wire logic        CLK_I,
  input  wire logic        RESET_I,
  input  wire logic        CE_I,
  input  wire logic        HSEL_I,
  input  wire logic [31:0] HADDR_I,
  input  wire logic [1:0]  HTRANS_I,
  input  wire logic        HWRITE_I,
  input  wire logic [2:0]  HSIZE_I,
  input  wire logic        HREADY_I,
  input  wire logic [31:0] HWDATA_I,
  output logic      [31:0] HRDATA_O,
  output logic             HREADYOUT_O,
  output logic             HRESP_O,
  output logic             IRQ_O,
  output logic      [15:0] EXT_ADDR_O,
  input  wire logic [15:0] EXT_DATA_I,
  output logic      [15:0] EXT_DATA_O,
  output logic             EXT_DATA_OEN_O,
  output logic             EXT_CS_N_O,
  output logic      [1:0]  EXT_BSEL_N_O,
  output logic             EXT_FRAME_O,
  output logic             EXT_FRAME_OEN_O,
  output logic             EXT_RD_O,
  output logic             EXT_RD_OEN_O,
  output logic             EXT_WR_O,
  output logic             EXT_WR_OEN_O,
  input  wire logic        EXT_READY_I
);
  localparam int unsigned PW = $clog2(NBR_DEPTH);

  ebi_link_if lk ();

  logic [31:0]   ctrl_reg;
  logic [31:0]   gpcfg_reg;
  logic [15:0]   addr_reg;
  logic [15:0]   wdata_reg;
  logic [31:0]   rdata_reg;
  logic [2:0]    cmd_reg;
  logic [1:0]    status_reg;
  logic [1:0]    status_next;
  logic [1:0]    mask_reg;
  logic          ph_valid_reg;
  logic          ph_write_reg;
  logic [7:0]    ph_addr_reg;
  logic [31:0]   hrdata_reg;
  logic [31:0]   rd_next;
  ebi_state_type state_reg;
  ebi_state_type state_next;
  logic [7:0]    wait_cnt_reg;
  logic [15:0]   data_s1_reg;
  logic [15:0]   data_s2_reg;
  logic          ready_s1_reg;
  logic          ready_s2_reg;
  logic [31:0]   nbr_mem [NBR_DEPTH];
  logic [PW-1:0] wp_reg;
  logic [PW-1:0] rp_reg;
  logic [PW:0]   cnt_reg;

  ebi_mode_type mode;
  logic         gp;
  logic         addr_phase;
  logic         wr_en;
  logic         rd_take;
  logic         go;
  logic         active;
  logic         finish;
  logic         timeout;
  logic         push;
  logic         pop;
  logic         wait_hit;
  logic [15:0]  rd_word;

  assign mode = ebi_mode_type'(ctrl_reg[`EBI_CTRL_MODE_LSB +: 2]);
  assign gp   = (mode == EBI_MODE_GP);

  // ----------------------------------------
  // Interface clock and hold-off timer
  // ----------------------------------------
  assign lk.div      = ctrl_reg[`EBI_CTRL_DIV_LSB +: 8];
  assign lk.sdram_en = (mode == EBI_MODE_SDRAM);

  ebi_clk_timer #(
    .HOLDOFF_CYCLES (HOLDOFF_CYCLES)
  ) u_timer (
    .CLK_I   (CLK_I),
    .RESET_I (RESET_I),
    .CE_I    (CE_I),
    .lk      (lk.timer)
  );

  // ----------------------------------------
  // AHB-Lite slave
  // ----------------------------------------
  assign addr_phase  = HSEL_I && HTRANS_I[1] && HREADY_I;
  assign wr_en       = ph_valid_reg && ph_write_reg;
  assign rd_take     = addr_phase && !HWRITE_I;
  assign HREADYOUT_O = 1'b1;
  assign HRESP_O     = 1'b0;
  assign HRDATA_O    = hrdata_reg;

  // Address phase capture
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      ph_valid_reg <= 1'b0;
      ph_write_reg <= 1'b0;
      ph_addr_reg  <= 8'h00;
    end else if (CE_I) begin
      ph_valid_reg <= addr_phase;
      ph_write_reg <= HWRITE_I;
      ph_addr_reg  <= HADDR_I[7:0];
    end
  end

  // Read mux, unmapped reads as zero
  always_comb begin
    rd_next = 32'h0000_0000;
    if (HADDR_I[7:0] == `EBI_OFF_CTRL) begin
      rd_next = ctrl_reg;
    end else if (HADDR_I[7:0] == `EBI_OFF_GPCFG) begin
      rd_next = gpcfg_reg;
    end else if (HADDR_I[7:0] == `EBI_OFF_ADDR) begin
      rd_next = {16'h0000, addr_reg};
    end else if (HADDR_I[7:0] == `EBI_OFF_WDATA) begin
      rd_next = {16'h0000, wdata_reg};
    end else if (HADDR_I[7:0] == `EBI_OFF_RDATA) begin
      rd_next = rdata_reg;
    end else if (HADDR_I[7:0] == `EBI_OFF_NBRDATA) begin
      rd_next = (cnt_reg != '0) ? nbr_mem[rp_reg] : 32'h0000_0000;
    end else if (HADDR_I[7:0] == `EBI_OFF_STATUS) begin
      rd_next = {30'h0000_0000, status_reg};
    end else if (HADDR_I[7:0] == `EBI_OFF_MASK) begin
      rd_next = {30'h0000_0000, mask_reg};
    end else if (HADDR_I[7:0] == `EBI_OFF_STATE) begin
      rd_next = {16'h0000, 8'(cnt_reg), 4'h0, lk.holdoff_done, state_reg};
    end
  end

  // Read data register, valid in the data phase
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      hrdata_reg <= 32'h0000_0000;
    end else if (CE_I && rd_take) begin
      hrdata_reg <= rd_next;
    end
  end

  // Software written configuration
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      ctrl_reg  <= `EBI_CTRL_RST;
      gpcfg_reg <= `EBI_GPCFG_RST;
      addr_reg  <= 16'h0000;
      wdata_reg <= 16'h0000;
      mask_reg  <= 2'h0;
    end else if (CE_I && wr_en) begin
      if (ph_addr_reg == `EBI_OFF_CTRL) begin
        ctrl_reg <= HWDATA_I;
      end else if (ph_addr_reg == `EBI_OFF_GPCFG) begin
        gpcfg_reg <= HWDATA_I;
      end else if (ph_addr_reg == `EBI_OFF_ADDR) begin
        addr_reg <= HWDATA_I[15:0];
      end else if (ph_addr_reg == `EBI_OFF_WDATA) begin
        wdata_reg <= HWDATA_I[15:0];
      end else if (ph_addr_reg == `EBI_OFF_MASK) begin
        mask_reg <= HWDATA_I[1:0];
      end
    end
  end

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      data_s1_reg  <= 16'h0000;
      data_s2_reg  <= 16'h0000;
      ready_s1_reg <= 1'b0;
      ready_s2_reg <= 1'b0;
    end else if (CE_I) begin
      data_s1_reg  <= EXT_DATA_I;
      data_s2_reg  <= data_s1_reg;
      ready_s1_reg <= EXT_READY_I;
      ready_s2_reg <= ready_s1_reg;
    end
  end

  // ----------------------------------------
  // Access engine
  // ----------------------------------------
  // Command accepted only when idle, mode on and, for a non-blocking read, queue has room
  assign go = wr_en && (ph_addr_reg == `EBI_OFF_CMD) && (state_reg == EBI_IDLE) && (mode != EBI_MODE_OFF)
              && !(HWDATA_I[`EBI_CMD_NBR] && !HWDATA_I[`EBI_CMD_WRITE] && cnt_reg == (PW+1)'(NBR_DEPTH));
  assign wait_hit = ready_s2_reg || (wait_cnt_reg >= gpcfg_reg[7:0]);
  assign finish   = lk.tick && (((state_reg == EBI_STROBE) && !gp) || ((state_reg == EBI_WAIT) && wait_hit));
  assign timeout  = lk.tick && (state_reg == EBI_WAIT) && !ready_s2_reg && (wait_cnt_reg >= gpcfg_reg[7:0]);
  assign active   = (state_reg == EBI_SETUP) || (state_reg == EBI_STROBE) || (state_reg == EBI_WAIT);

  // Next state
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      EBI_IDLE: begin
        if (go) begin
          state_next = EBI_HOLD;
        end
      end
      EBI_HOLD: begin
        if (lk.tick && !(lk.sdram_en && !lk.holdoff_done)) begin // R01
          state_next = EBI_SETUP;
        end
      end
      EBI_SETUP: begin
        if (lk.tick) begin
          state_next = EBI_STROBE;
        end
      end
      EBI_STROBE: begin
        if (lk.tick) begin
          state_next = gp ? EBI_WAIT : EBI_DONE;
        end
      end
      EBI_WAIT: begin
        if (finish) begin
          state_next = EBI_DONE;
        end
      end
      default: begin
        state_next = EBI_IDLE;
      end
    endcase
  end

  // State and command latch
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      state_reg <= EBI_IDLE;
      cmd_reg   <= 3'h0;
    end else if (CE_I) begin
      state_reg <= state_next;
      if (go) begin
        cmd_reg <= HWDATA_I[2:0];
      end
    end
  end

  // Ready wait counter, advanced on interface ticks only
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      wait_cnt_reg <= 8'h00;
    end else if (CE_I) begin
      if (state_reg != EBI_WAIT) begin
        wait_cnt_reg <= 8'h00;
      end else if (lk.tick && !wait_hit) begin
        wait_cnt_reg <= wait_cnt_reg + 8'h01; // R09
      end
    end
  end

  // ----------------------------------------
  // Read results and non-blocking queue
  // ----------------------------------------
  assign rd_word = (cmd_reg[`EBI_CMD_BYTE] && addr_reg[0]) ? {8'h00, data_s2_reg[15:8]}
                 : cmd_reg[`EBI_CMD_BYTE] ? {8'h00, data_s2_reg[7:0]} : data_s2_reg;
  assign push = finish && cmd_reg[`EBI_CMD_NBR] && !cmd_reg[`EBI_CMD_WRITE];
  assign pop  = rd_take && (HADDR_I[7:0] == `EBI_OFF_NBRDATA) && (cnt_reg != '0);

  // Blocking read data
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      rdata_reg <= 32'h0000_0000;
    end else if (CE_I && finish && !cmd_reg[`EBI_CMD_WRITE] && !cmd_reg[`EBI_CMD_NBR]) begin
      rdata_reg <= {16'h0000, rd_word};
    end
  end

  // Queue storage
  always_ff @(posedge CLK_I) begin
    if (CE_I && push) begin
      nbr_mem[wp_reg] <= {16'h0000, rd_word};
    end
  end

  // Queue pointers and count
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      wp_reg  <= '0;
      rp_reg  <= '0;
      cnt_reg <= '0;
    end else if (CE_I) begin
      if (push) begin
        wp_reg <= (wp_reg == PW'(NBR_DEPTH - 1)) ? '0 : wp_reg + PW'(1);
      end
      if (pop) begin
        rp_reg <= (rp_reg == PW'(NBR_DEPTH - 1)) ? '0 : rp_reg + PW'(1);
      end
      cnt_reg <= cnt_reg + (PW+1)'(push) - (PW+1)'(pop); // R05
    end
  end

  // ----------------------------------------
  // Interrupt status, write one to clear
  // ----------------------------------------
  always_comb begin
    status_next = status_reg;
    if (wr_en && ph_addr_reg == `EBI_OFF_STATUS) begin
      status_next = status_next & ~HWDATA_I[1:0];
    end
    status_next[`EBI_ST_NBR] = status_next[`EBI_ST_NBR] | push; // R06
    status_next[`EBI_ST_TMO] = status_next[`EBI_ST_TMO] | timeout;
  end

  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      status_reg <= 2'h0;
    end else if (CE_I) begin
      status_reg <= status_next;
    end
  end
  assign IRQ_O = |(status_reg & mask_reg);

  // ----------------------------------------
  // External pins
  // ----------------------------------------
  assign EXT_ADDR_O     = addr_reg;
  assign EXT_DATA_O     = wdata_reg;
  assign EXT_DATA_OEN_O = !(active && cmd_reg[`EBI_CMD_WRITE]);
  assign EXT_CS_N_O     = !active;
  assign EXT_FRAME_O    = gp && active;
  assign EXT_RD_O       = ((state_reg == EBI_STROBE) || (state_reg == EBI_WAIT)) && !cmd_reg[`EBI_CMD_WRITE];
  assign EXT_WR_O       = ((state_reg == EBI_STROBE) || (state_reg == EBI_WAIT)) && cmd_reg[`EBI_CMD_WRITE];

  // Pin enables, low while driven
  assign EXT_FRAME_OEN_O = !(gp && ctrl_reg[`EBI_CTRL_FRAME]); // R07
  assign EXT_RD_OEN_O    = gp && !ctrl_reg[`EBI_CTRL_STRB];    // R08
  assign EXT_WR_OEN_O    = gp && !ctrl_reg[`EBI_CTRL_STRB];    // R08

  // Byte selects, both on for reads
  always_comb begin
    EXT_BSEL_N_O = 2'b11;
    if (active) begin
      EXT_BSEL_N_O = 2'b00; // R04
      if (mode == EBI_MODE_HB16 && cmd_reg[`EBI_CMD_WRITE] && cmd_reg[`EBI_CMD_BYTE]) begin
        EXT_BSEL_N_O = addr_reg[0] ? 2'b01 : 2'b10;
      end
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RESET_I);

  sequence s_strobe_end;
    (state_reg == EBI_STROBE) && lk.tick && CE_I && !gp;
  endsequence
  sequence s_nbr_done;
    push && CE_I && mask_reg[`EBI_ST_NBR];
  endsequence

  a_sdram_block: assert property ((lk.sdram_en && !lk.holdoff_done) |-> EXT_CS_N_O) // R01
    else $error("sdram access during hold-off");
  a_bsel_read: assert property ((!EXT_CS_N_O && !cmd_reg[`EBI_CMD_WRITE]) |-> EXT_BSEL_N_O == 2'b00) // R04
    else $error("read without both byte selects");
  a_count_quiet: assert property ((!push && !pop) |=> $stable(cnt_reg)) // R05
    else $error("queue count moved without queue activity");
  a_done_irq: assert property (s_nbr_done |=> status_reg[`EBI_ST_NBR] && IRQ_O) // R06
    else $error("no completion interrupt");
  a_frame_off: assert property (!ctrl_reg[`EBI_CTRL_FRAME] |-> EXT_FRAME_OEN_O) // R07
    else $error("frame driven while disabled");
  a_strobe_off: assert property ((gp && !ctrl_reg[`EBI_CTRL_STRB]) |-> EXT_RD_OEN_O && EXT_WR_OEN_O) // R08
    else $error("strobe driven while disabled");
  a_wait_bound: assert property ((state_reg == EBI_WAIT) |-> wait_cnt_reg <= gpcfg_reg[7:0]) // R09
    else $error("ready wait above limit");
  a_wait_ticks: assert property ((state_reg == EBI_WAIT && !lk.tick) |=> $stable(wait_cnt_reg)) // R09
    else $error("ready wait counted a system clock");
  a_strobe_done: assert property (s_strobe_end |=> state_reg == EBI_DONE ##1 state_reg == EBI_IDLE)
    else $error("access did not finish");
endmodule // ebi_top
